/* hw/mcomm_regs.vh */
// constants for the multiphase commutation output block
`ifndef MCOMM_REGS_VH
`define MCOMM_REGS_VH
`define MCOMM_MODE_SENSORED   2'h3
`define MCOMM_MODE_LINK       2'h2
`define MCOMM_SRQ_NONE        2'h0
`define MCOMM_SRQ_FORCE       2'h2
`define MCOMM_SRQ_FORCE_TEST  2'h3
`define MCOMM_PRIO_OFF        2'h0
`define MCOMM_A_CTRL          4'h0
`define MCOMM_A_PINS          4'h1
`define MCOMM_A_DELAY         4'h2
`define MCOMM_A_STATE_IDX     4'h3
`define MCOMM_A_STATE_CNT     4'h4
`define MCOMM_A_POSITION      4'h5
`define MCOMM_A_UPPER         4'h6
`define MCOMM_A_LOWER         4'h7
`define MCOMM_A_OFFSET        4'h8
`define MCOMM_A_STATUS        4'h9
`define MCOMM_A_TBC           4'ha
`define MCOMM_A_TABLE         4'hf
`define MCOMM_CTRL_SRQ_LSB    0
`define MCOMM_CTRL_MODE_LSB   2
`define MCOMM_CTRL_PRIO_LSB   4
`define MCOMM_CTRL_FUNC_LSB   6
`define MCOMM_FORCE_BASE      8'h18
`define MCOMM_LINK_BASE       8'h40
`define MCOMM_MATCH_BASE      8'h3e
`define MCOMM_PER_PIN         8'h0e
`endif

/* hw/mcomm_table_mem.v */
// state table memory with registered read
`timescale 1ns/1ps
module mcomm_table_mem #(
   parameter AW = 4,
   parameter DW = 16
) (
   clk,
   we,
   waddr,
   wdata,
   raddr,
   rdata_q
);
   input  wire          clk;
   input  wire          we;
   input  wire [AW-1:0] waddr;
   input  wire [DW-1:0] wdata;
   input  wire [AW-1:0] raddr;
   output reg  [DW-1:0] rdata_q;
   reg [DW-1:0] mem [0:(1<<AW)-1];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule

/* hw/mcomm_top.v */
// multiphase commutation output block
// Operation
// R1: host disables channels before function select
// R2: host then writes mode select bits
// R3: mode 11 sensored, 10 link, else match
// R4: host writes pins, delay, table, index
// R5: service code 10 forces indexed state
// R6: host enables priority after request
// R7: end of service clears request, sets flag
// R8: initial levels appear within update delay
// R9: hall decoder links new index when needed
// R10: sensorless host setup of parameters
// R11: host writes angle bounds then offset
// R12: link mode updates on every link
// R13: code 11 starts periodic match updates
// R14: service cost cycles per state type
// R15: link fetches pattern, schedules match
// R16: all pins change together at match
// R17: host keeps delay above minimum service
// R18: code 00 idle, 11 force then test
// R19: pin pattern right justified in entry
// R20: channel n drives pattern bit n
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "mcomm_regs.vh"
module mcomm_top #(
   parameter NPIN = 8,
   parameter AW   = 4
) (
   clk,
   rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata_q,
   link_req,
   link_state,
   pos_count,
   comm_pins_q,
   service_flag_q
);
   input  wire            clk;
   input  wire            rst;
   input  wire [3:0]      reg_addr;
   input  wire [15:0]     reg_wdata;
   input  wire            reg_wr;
   input  wire            reg_rd;
   output reg  [15:0]     reg_rdata_q;
   input  wire            link_req;
   input  wire [AW-1:0]   link_state;
   input  wire [15:0]     pos_count;
   output reg  [NPIN-1:0] comm_pins_q;
   output reg             service_flag_q;

   localparam S_IDLE  = 3'h0;
   localparam S_FETCH = 3'h1;
   localparam S_WAIT  = 3'h2;
   localparam S_LOAD  = 3'h3;
   localparam S_ARM   = 3'h4;

   reg [1:0]      srq_q, mode_q, prio_q;
   reg [4:0]      func_q;
   reg [3:0]      pins_q;
   reg [15:0]     delay_q, upper_q, lower_q, offset_q, tbc_q, match_t_q;
   reg [15:0]     pos_q;
   reg [AW-1:0]   idx_q, cnt_q, tab_waddr_q;
   reg [2:0]      st_q;
   reg [8:0]      cost_q;
   reg            test_q, periodic_q, armed_q, is_force_q;
   reg [NPIN-1:0] next_pins_q;
   wire [15:0]    tab_rdata;
   wire           tab_we = reg_wr && reg_addr == `MCOMM_A_TABLE;
   wire           enabled = prio_q != `MCOMM_PRIO_OFF;
   wire           periodic_hit = periodic_q && tbc_q == match_t_q;
   wire           link_mode = mode_q == `MCOMM_MODE_LINK; //R3
   wire           sens_mode = mode_q == `MCOMM_MODE_SENSORED; //R3
   wire [15:0]    pos_adj = pos_q + offset_q;
   wire [8:0]     pin_cost = {5'h00, pins_q} * {1'b0, `MCOMM_PER_PIN}; //R14

   mcomm_table_mem #(.AW(AW), .DW(16)) u_mem (
      .clk     (clk),
      .we      (tab_we),
      .waddr   (tab_waddr_q),
      .wdata   (reg_wdata),
      .raddr   (idx_q),
      .rdata_q (tab_rdata)
   );

   // free running time base
   always @(posedge clk) begin
      if (rst) begin
         tbc_q <= 16'h0000;
      end else begin
         tbc_q <= tbc_q + 16'h0001;
      end
   end

   // register writes and service sequencing
   always @(posedge clk) begin
      if (rst) begin
         srq_q <= `MCOMM_SRQ_NONE; //R18
         mode_q <= 2'h0;
         prio_q <= 2'h0;
         func_q <= 5'h00;
         pins_q <= 4'h0;
         delay_q <= 16'h0000;
         upper_q <= 16'h0000;
         lower_q <= 16'h0000;
         offset_q <= 16'h0000;
         pos_q <= 16'h0000;
         idx_q <= {AW{1'b0}};
         cnt_q <= {AW{1'b0}};
         tab_waddr_q <= {AW{1'b0}};
         st_q <= S_IDLE;
         cost_q <= 9'h000;
         test_q <= 1'b0;
         periodic_q <= 1'b0;
         armed_q <= 1'b0;
         is_force_q <= 1'b0;
         match_t_q <= 16'h0000;
         next_pins_q <= {NPIN{1'b0}};
         comm_pins_q <= {NPIN{1'b0}};
         service_flag_q <= 1'b0;
         reg_rdata_q <= 16'h0000;
      end else begin
         pos_q <= pos_count;
         if (reg_wr) begin
            case (reg_addr)
               `MCOMM_A_CTRL: begin
                  srq_q  <= reg_wdata[`MCOMM_CTRL_SRQ_LSB +: 2];
                  mode_q <= reg_wdata[`MCOMM_CTRL_MODE_LSB +: 2];
                  prio_q <= reg_wdata[`MCOMM_CTRL_PRIO_LSB +: 2];
                  func_q <= reg_wdata[`MCOMM_CTRL_FUNC_LSB +: 5];
               end
               `MCOMM_A_PINS:      pins_q <= reg_wdata[3:0];
               `MCOMM_A_DELAY:     delay_q <= reg_wdata;
               `MCOMM_A_STATE_IDX: idx_q <= reg_wdata[AW-1:0];
               `MCOMM_A_STATE_CNT: cnt_q <= reg_wdata[AW-1:0];
               `MCOMM_A_UPPER:     upper_q <= reg_wdata;
               `MCOMM_A_LOWER:     lower_q <= reg_wdata;
               `MCOMM_A_OFFSET:    offset_q <= reg_wdata;
               `MCOMM_A_STATUS:    service_flag_q <= 1'b0;
               `MCOMM_A_TABLE:     tab_waddr_q <= tab_waddr_q + 1'b1;
               `MCOMM_A_TBC:       tab_waddr_q <= reg_wdata[AW-1:0];
               default: ;
            endcase
         end
         if (reg_rd) begin
            case (reg_addr)
               `MCOMM_A_CTRL: reg_rdata_q <= {5'h00, func_q, prio_q,
                                              mode_q, srq_q};
               `MCOMM_A_PINS:      reg_rdata_q <= {12'h000, pins_q};
               `MCOMM_A_DELAY:     reg_rdata_q <= delay_q;
               `MCOMM_A_STATE_IDX: reg_rdata_q <= {{(16-AW){1'b0}}, idx_q};
               `MCOMM_A_STATE_CNT: reg_rdata_q <= {{(16-AW){1'b0}}, cnt_q};
               `MCOMM_A_POSITION:  reg_rdata_q <= pos_q;
               `MCOMM_A_UPPER:     reg_rdata_q <= upper_q;
               `MCOMM_A_LOWER:     reg_rdata_q <= lower_q;
               `MCOMM_A_OFFSET:    reg_rdata_q <= offset_q;
               `MCOMM_A_STATUS:    reg_rdata_q <= {12'h000, armed_q,
                                     periodic_q, st_q != S_IDLE,
                                     service_flag_q};
               `MCOMM_A_TBC:       reg_rdata_q <= tbc_q;
               default:            reg_rdata_q <= 16'h0000;
            endcase
         end
         // all channels change together at the match
         if (armed_q && tbc_q == match_t_q) begin
            comm_pins_q <= next_pins_q; //R16 R8 R20
            armed_q <= 1'b0;
            if (periodic_q) begin
               match_t_q <= match_t_q + delay_q;
            end
         end
         case (st_q)
            S_IDLE: begin
               if (enabled && srq_q != `MCOMM_SRQ_NONE &&
                   srq_q[1]) begin //R5 R13
                  st_q <= S_FETCH;
                  is_force_q <= 1'b1;
                  test_q <= srq_q == `MCOMM_SRQ_FORCE_TEST; //R18 R13
                  cost_q <= {1'b0, `MCOMM_FORCE_BASE} + pin_cost; //R14
                  match_t_q <= tbc_q + delay_q;
               end else if (enabled && link_req && sens_mode) begin
                  idx_q <= link_state; //R15
                  st_q <= S_FETCH;
                  is_force_q <= 1'b0;
                  cost_q <= {1'b0, `MCOMM_LINK_BASE} + pin_cost; //R14
                  match_t_q <= tbc_q + delay_q; //R15
               end else if (enabled && link_req && link_mode) begin
                  st_q <= S_FETCH; //R12
                  is_force_q <= 1'b0;
                  cost_q <= {1'b0, `MCOMM_LINK_BASE} + pin_cost;
                  match_t_q <= tbc_q + delay_q;
               end else if (enabled && periodic_hit) begin
                  st_q <= S_FETCH; //R13
                  is_force_q <= 1'b0;
                  cost_q <= {1'b0, `MCOMM_MATCH_BASE} + pin_cost; //R14
                  // next periodic slot one period after this one
                  match_t_q <= match_t_q + delay_q; //R13
               end
            end
            S_FETCH: begin
               // state test in sensorless modes steps index by angle
               if (!is_force_q && !sens_mode) begin
                  if ($signed(pos_adj - upper_q) > 0) begin
                     idx_q <= (idx_q + 1'b1 >= cnt_q) ? {AW{1'b0}}
                              : idx_q + 1'b1;
                  end else if ($signed(pos_adj - lower_q) < 0) begin
                     idx_q <= (idx_q == {AW{1'b0}}) ? cnt_q - 1'b1
                              : idx_q - 1'b1;
                  end
               end
               st_q <= S_WAIT;
            end
            S_WAIT: begin
               if (cost_q != 9'h000) begin
                  cost_q <= cost_q - 9'h001;
               end else begin
                  st_q <= S_LOAD;
               end
            end
            S_LOAD: begin
               next_pins_q <= tab_rdata[NPIN-1:0]; //R19
               armed_q <= 1'b1; //R15
               st_q <= S_ARM;
            end
            S_ARM: begin
               if (is_force_q) begin
                  srq_q <= `MCOMM_SRQ_NONE; //R7
                  service_flag_q <= 1'b1; //R7
                  periodic_q <= test_q && !sens_mode && !link_mode;
               end
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule

/* test/mcomm_props.sv */
// assertion checker for the commutation output block
`timescale 1ns/1ps
`include "mcomm_regs.vh"
module mcomm_chk #(parameter NPIN = 8, parameter AW = 4) (
   input wire            clk,
   input wire            rst,
   input wire [3:0]      reg_addr,
   input wire [15:0]     reg_wdata,
   input wire            reg_wr,
   input wire            reg_rd,
   input wire [15:0]     reg_rdata_q,
   input wire            link_req,
   input wire [NPIN-1:0] comm_pins_q,
   input wire            service_flag_q
);
   reg  started_q;
   reg  pend_q;
   wire ctrl_wr = reg_wr && reg_addr == `MCOMM_A_CTRL;
   wire stat_wr = reg_wr && reg_addr == `MCOMM_A_STATUS;
   // tracks whether any service could have begun since reset
   always @(posedge clk) begin
      started_q <= !rst && (started_q || ctrl_wr || link_req);
      pend_q <= !rst && (pend_q || (ctrl_wr && reg_wdata[1]));
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_reset_clears_out: assert property (
      $past(rst) |-> comm_pins_q == 0 && !service_flag_q)
      else $error("outputs not cleared by reset");
   chk_pins_idle_still: assert property (!started_q |-> comm_pins_q == 0)
      else $error("pins moved without a service");
   chk_flag_has_cause: assert property ($rose(service_flag_q) |-> pend_q)
      else $error("flag set without a forced service");
   chk_force_done_bound: assert property (
      ctrl_wr && reg_wdata[1] && reg_wdata[5:4] != 2'h0
      |-> ##[1:300] service_flag_q) else $error("forced service never ended");
   chk_flag_clear_write: assert property (stat_wr |=> !service_flag_q)
      else $error("flag not cleared");
   chk_flag_holds_set: assert property (
      service_flag_q && !stat_wr |=> service_flag_q)
      else $error("flag dropped by itself");
   chk_unmapped_reads_zero: assert property (
      reg_rd && reg_addr inside {[4'hb:4'he]} |=> reg_rdata_q == 16'h0000)
      else $error("unmapped read not zero");
   chk_status_upper_zero: assert property (
      reg_rd && reg_addr == `MCOMM_A_STATUS |=> reg_rdata_q[15:4] == 12'h000)
      else $error("status upper bits set");
   cover property ($rose(service_flag_q));
   cover property ($changed(comm_pins_q) && started_q);
   cover property (link_req ##1 !link_req);
endmodule
bind mcomm_top mcomm_chk #(.NPIN(NPIN), .AW(AW)) chk_u (.clk, .rst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .link_req,
   .comm_pins_q, .service_flag_q);

/* test/mcomm_hall_model.sv */
// hall decoder partner model driving links and position count
`timescale 1ns/1ps
module mcomm_hall_model #(parameter AW = 4) (
   input  wire          clk,
   input  wire          go,
   input  wire [AW-1:0] new_state,
   output reg           link_req = 1'b0,
   output reg  [AW-1:0] link_state = {AW{1'b0}},
   output reg  [15:0]   pos_count = 16'h0100
);
   always @(posedge clk) begin
      link_req <= go;
      // index only valid beside the link, scrambled otherwise
      link_state <= go ? new_state : ~link_state;
      if (go) begin
         pos_count <= pos_count + 16'h0001;
      end
   end
endmodule

/* test/mcomm_top_bench.sv */
// self-checking bench for the commutation output block
`timescale 1ns/1ps
`include "mcomm_regs.vh"
module mcomm_top_bench;
   localparam [15:0] DLY = 16'h0100;
   localparam [4:0]  FUNC = 5'h0d;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [3:0]  reg_addr = 4'h0;
   reg  [15:0] reg_wdata = 16'h0000;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg         go = 1'b0;
   reg  [3:0]  new_state = 4'h0;
   wire [15:0] reg_rdata_q;
   wire        link_req;
   wire [3:0]  link_state;
   wire [15:0] pos_count;
   wire [7:0]  comm_pins_q;
   wire        service_flag_q;
   reg  [15:0] tbl [0:3];
   reg  [15:0] rd_v;
   integer     miscompares = 0;
   integer     compares = 0;
   integer     i;
   always #20 clk = ~clk;
   mcomm_top #(.NPIN(8), .AW(4)) dut_u (.clk, .rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata_q, .link_req, .link_state, .pos_count,
      .comm_pins_q, .service_flag_q);
   mcomm_hall_model #(.AW(4)) partner_u (.clk, .go, .new_state, .link_req,
      .link_state, .pos_count);
   task check(input [15:0] got, input [15:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 rd_v = reg_rdata_q;
      end
   endtask
   task link(input [3:0] s);
      begin
         @(posedge clk);
         go <= 1'b1;
         new_state <= s;
         @(posedge clk);
         go <= 1'b0;
      end
   endtask
   task wait_pins(input [7:0] e);
      begin
         #1 i = 0;
         while (comm_pins_q !== e && i < 300) begin
            @(posedge clk);
            #1 i = i + 1;
         end
         check({8'h00, comm_pins_q}, {8'h00, e});
      end
   endtask
   function [15:0] ctrl(input [1:0] c, input [1:0] m, input [1:0] p);
      ctrl = {5'h00, FUNC, p, m, c};
   endfunction
   task force_state(input [1:0] m, input [1:0] c, input [1:0] idx);
      begin
         wr(`MCOMM_A_CTRL, ctrl(`MCOMM_SRQ_NONE, m, `MCOMM_PRIO_OFF));
         wr(`MCOMM_A_STATE_IDX, {14'h0000, idx});
         wr(`MCOMM_A_STATE_CNT, 16'h0004);
         wr(`MCOMM_A_CTRL, ctrl(c, m, 2'h1));
         i = 0;
         while (service_flag_q !== 1'b1 && i < 400) begin
            @(posedge clk);
            #1 i = i + 1;
         end
         check({15'h0000, service_flag_q}, 16'h0001);
         rd(`MCOMM_A_CTRL);
         check({14'h0000, rd_v[1:0]}, 16'h0000);
         wait_pins(tbl[idx][7:0]);
         wr(`MCOMM_A_STATUS, 16'h0000);
         #1 check({15'h0000, service_flag_q}, 16'h0000);
      end
   endtask
   task end_of_test;
      begin
         $display("compares %0d miscompares %0d", compares, miscompares);
         if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
         end else begin
            $display("DONE - FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      tbl[0] = 16'h0135;
      tbl[1] = 16'h02ca;
      tbl[2] = 16'h0396;
      tbl[3] = 16'h0469;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(`MCOMM_A_CTRL);
      check({14'h0000, rd_v[1:0]}, 16'h0000);
      rd(4'hc);
      check(rd_v, 16'h0000);
      wr(`MCOMM_A_PINS, 16'h0008);
      wr(`MCOMM_A_DELAY, DLY);
      wr(`MCOMM_A_TBC, 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`MCOMM_A_TABLE, tbl[i]);
      end
      force_state(`MCOMM_MODE_SENSORED, `MCOMM_SRQ_FORCE, 2'h2);
      link(4'h1);
      repeat (100) @(posedge clk);
      #1 check({8'h00, comm_pins_q}, {8'h00, tbl[2][7:0]});
      wait_pins(tbl[1][7:0]);
      // priority off: the link must be ignored
      wr(`MCOMM_A_CTRL, ctrl(2'h0, `MCOMM_MODE_SENSORED, 2'h0));
      link(4'h3);
      repeat (400) @(posedge clk);
      #1 check({8'h00, comm_pins_q}, {8'h00, tbl[1][7:0]});
      force_state(`MCOMM_MODE_LINK, `MCOMM_SRQ_FORCE, 2'h0);
      // link with bounds at zero steps the index forward
      link(4'h0);
      wait_pins(tbl[1][7:0]);
      force_state(2'h1, `MCOMM_SRQ_FORCE, 2'h3);
      rd(`MCOMM_A_POSITION);
      check(rd_v, 16'h0103);
      wr(`MCOMM_A_UPPER, rd_v + 16'h0008);
      wr(`MCOMM_A_LOWER, rd_v - 16'h0008);
      wr(`MCOMM_A_OFFSET, 16'h0000);
      force_state(2'h0, `MCOMM_SRQ_FORCE_TEST, 2'h1);
      // offset pushes the angle past the upper bound
      wr(`MCOMM_A_OFFSET, 16'h0010);
      repeat (300) @(posedge clk);
      #1 check({8'h00, comm_pins_q}, {8'h00, tbl[1][7:0]});
      wait_pins(tbl[2][7:0]);
      wait_pins(tbl[3][7:0]);
      end_of_test;
   end
   initial begin
      #800000;
      miscompares = miscompares + 1;
      end_of_test;
   end
endmodule
